//--- core/bcrs_pkg.sv
// Constants shared by the boot clock and reset sequencer.
// Assumes a single 250 MHz clock taken from the primary clock input.
package bcrs_pkg;
  localparam int          CLK_PERIOD_PS      = 4000;
  // Crystal settling time in microseconds.
  localparam int          XTAL_SETTLE_US     = 1000;
  localparam int          XTAL_SETTLE_CYCLES = (XTAL_SETTLE_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [31:0] RESET_VECTOR       = 32'ha000_0000;
  localparam int          ADDR_W             = 32;
  // Address bits from this position up select the segment.
  localparam int          SEG_LSB            = 29;
  localparam logic [2:0]  PHYS_SEG_ZERO      = 3'h0;
  localparam logic [2:0]  SEG_FIXED_UNCACHED = 3'h5;
  localparam logic [28:0] SEG_OFFSET_MASK    = 29'h1fff_ffff;
  localparam logic [31:0] BOOT_CS_BASE       = 32'h0000_0000;
  localparam logic [31:0] BOOT_CS_LIMIT      = 32'h0400_0000;
  localparam int          NUM_PLLS           = 2;
  localparam int          NUM_MODULES        = 8;
  localparam int          DIV_W              = 4;
  localparam logic [3:0]  DIV_NONE           = 4'h0;
  localparam int          CNT_W              = 32;
  typedef enum logic [1:0] {BCRS_ST_POR, BCRS_ST_SETTLE, BCRS_ST_RUN} bcrs_state_t;
endpackage

//--- core/bcrs_clk_slot.sv
// One module clock slot: gate and divider enable pulse.
// Assumes control inputs are synchronous to clock_i.
`timescale 1ns/1ps
module bcrs_clk_slot
  import bcrs_pkg::*;
(
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  // Control
  input  wire logic             gate_off_i,
  input  wire logic [DIV_W-1:0] div_i,
  // Output
  output logic                  clk_en_o
);
  logic [DIV_W-1:0] count;

  always_ff @(posedge clock_i) begin
    if (reset_i || count >= div_i) begin
      count <= DIV_NONE;
    end else begin
      count <= count + 1'b1;
    end
  end

  // With no division every edge is enabled; gating removes the enable.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      clk_en_o <= 1'b1;
    end else begin
      clk_en_o <= !gate_off_i && (count == DIV_NONE || div_i == DIV_NONE);
    end
  end
endmodule // bcrs_clk_slot

//--- core/bcrs_sequencer.sv
// Boot clock and reset sequencer: clock source, crystal settling, boot fetch decode.
// Assumes clock_i is the primary clock input and reset_i is the supply-ramp reset.
`timescale 1ns/1ps
// Functional notes
// - After supply reset, system clock comes only from the primary clock input.
// - Sample the oscillator select strap to know crystal or external clock.
// - With crystal selected, hold internal reset until the oscillator settles.
// - With external clock selected, release reset with no settling delay.
// - PLLs start disabled and are unused until software enables them.
// - All module clocks run at start-up; none gated by default.
// - No divider active at start-up; all clocks equal input frequency.
// - First fetch after reset is at virtual address 0xA000_0000.
// - Fixed uncached segment bypasses translation and cache, maps to physical zero.
// - Physical zero decodes to the boot chip select of the external bus.
// - Software may later enable PLLs, divide and gate peripheral clocks.
module bcrs_sequencer
  import bcrs_pkg::*;
#(
  parameter int SETTLE_CYCLES = XTAL_SETTLE_CYCLES
)(
  // Clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         reset_i,
  // Board strap: high selects an external clock, low a crystal
  input  wire logic                         oscillator_select_strap_i,
  // Software clock control after boot
  input  wire logic [NUM_PLLS-1:0]          pll_enable_i,
  input  wire logic [NUM_MODULES-1:0]       clk_gate_off_i,
  input  wire logic [NUM_MODULES*DIV_W-1:0] clk_div_i,
  // Fetch address from the processor
  input  wire logic                         fetch_valid_i,
  input  wire logic [31:0]                  fetch_vaddr_i,
  // Clock tree and reset outputs
  output logic                              sys_reset_o,
  output logic                              clk_from_pll_o,
  output logic [NUM_PLLS-1:0]               pll_enabled_o,
  output logic [NUM_MODULES-1:0]            module_clk_en_o,
  // Boot fetch outputs
  output logic [31:0]                       boot_pc_o,
  output logic [31:0]                       fetch_paddr_o,
  output logic                              fetch_uncached_o,
  output logic                              boot_chip_select_o
);
  bcrs_state_t                     state;
  logic        [CNT_W-1:0]         settle_count;
  logic                            settle_done;
  logic                            sw_ctrl_live;
  logic                            slot_reset;
  logic        [NUM_MODULES-1:0]   slot_gate_off;
  logic                            fetch_take;
  logic                            seg_hit;
  logic        [ADDR_W-1:0]        next_paddr;
  logic                            next_uncached;
  logic                            next_boot_select;

  ////////////////////////////////////////////////////////////////////////////
  // Strap sampling and reset sequence.

  // The strap is read once, in the first cycle after supply reset ends.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= BCRS_ST_POR;
    end else begin
      unique case (state)
        BCRS_ST_POR: begin
          if (oscillator_select_strap_i) begin
            state <= BCRS_ST_RUN;
          end else begin
            state <= BCRS_ST_SETTLE;
          end
        end
        BCRS_ST_SETTLE: begin
          if (settle_done) begin
            state <= BCRS_ST_RUN;
          end
        end
        BCRS_ST_RUN: begin
          state <= BCRS_ST_RUN;
        end
        // The unused code falls back to the start of the sequence.
        default: begin
          state <= BCRS_ST_POR;
        end
      endcase
    end
  end

  // Counts edges of the primary oscillator while settling.
  always_ff @(posedge clock_i) begin
    if (reset_i || state != BCRS_ST_SETTLE) begin
      settle_count <= '0;
    end else begin
      settle_count <= settle_count + 1'b1;
    end
  end

  // Terminal count: the last settling cycle before reset may drop.
  always_comb begin
    settle_done = (settle_count >= CNT_W'(SETTLE_CYCLES - 1));
  end

  // Internal reset follows the sequencer one cycle late, so it drops cleanly.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= (state != BCRS_ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock tree control.

  // Software clock controls are ignored while internal reset is held.
  always_comb begin
    sw_ctrl_live = !sys_reset_o;
  end

  // PLLs stay off while reset is held; software enables them afterwards.
  always_ff @(posedge clock_i) begin
    if (reset_i || !sw_ctrl_live) begin
      pll_enabled_o <= '0;
    end else begin
      pll_enabled_o <= pll_enable_i;
    end
  end

  // Primary input is the only source until a PLL is running.
  always_ff @(posedge clock_i) begin
    if (reset_i || !sw_ctrl_live) begin
      clk_from_pll_o <= 1'b0;
    end else begin
      clk_from_pll_o <= |pll_enabled_o;
    end
  end

  // Every slot runs ungated and undivided until software takes over.
  always_comb begin
    slot_reset    = reset_i || sys_reset_o;
    slot_gate_off = clk_gate_off_i & {NUM_MODULES{sw_ctrl_live}};
  end

  for (genvar m = 0; m < NUM_MODULES; m++) begin : g_slot
    logic [DIV_W-1:0] slot_div;

    always_comb begin
      if (sw_ctrl_live) begin
        slot_div = clk_div_i[m*DIV_W +: DIV_W];
      end else begin
        slot_div = DIV_NONE;
      end
    end

    bcrs_clk_slot u_slot (
      .clock_i    (clock_i),
      .reset_i    (slot_reset),
      .gate_off_i (slot_gate_off[m]),
      .div_i      (slot_div),
      .clk_en_o   (module_clk_en_o[m])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot fetch address decode.

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      boot_pc_o <= RESET_VECTOR;
    end else begin
      boot_pc_o <= RESET_VECTOR;
    end
  end

  // Fetches are refused without indication while internal reset is held.
  always_comb begin
    fetch_take = fetch_valid_i && sw_ctrl_live;
    seg_hit    = (fetch_vaddr_i[ADDR_W-1:SEG_LSB] == SEG_FIXED_UNCACHED);
  end

  // The fixed segment drops its selector bits and bypasses the caches.
  always_comb begin
    if (seg_hit) begin
      next_paddr    = {PHYS_SEG_ZERO, fetch_vaddr_i[SEG_LSB-1:0] & SEG_OFFSET_MASK};
      next_uncached = 1'b1;
    end else begin
      next_paddr    = fetch_vaddr_i;
      next_uncached = 1'b0;
    end
  end

  // The boot chip select covers the bottom window of physical space.
  always_comb begin
    next_boot_select = (next_paddr < BOOT_CS_LIMIT);
  end

  // Decode results stand until the next accepted fetch.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fetch_paddr_o <= BOOT_CS_BASE;
    end else if (fetch_take) begin
      fetch_paddr_o <= next_paddr;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fetch_uncached_o <= 1'b1;
    end else if (fetch_take) begin
      fetch_uncached_o <= next_uncached;
    end
  end

  // One pulse per accepted fetch that lands in the boot window.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      boot_chip_select_o <= 1'b0;
    end else begin
      boot_chip_select_o <= fetch_take && next_boot_select;
    end
  end
endmodule // bcrs_sequencer

//--- dv/bcrs_monitor.sv
// Port checker for the boot clock and reset sequencer.
// Assumes the bind below hands on SETTLE_CYCLES.
`timescale 1ns/1ps
module bcrs_monitor
  import bcrs_pkg::*;
#(
  parameter int SETTLE_CYCLES = 8
)(
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   reset_i,
  // Design inputs
  input  wire logic                   oscillator_select_strap_i,
  input  wire logic [NUM_PLLS-1:0]    pll_enable_i,
  input  wire logic                   fetch_valid_i,
  input  wire logic [31:0]            fetch_vaddr_i,
  // Design outputs
  input  wire logic                   sys_reset_o,
  input  wire logic                   clk_from_pll_o,
  input  wire logic [NUM_PLLS-1:0]    pll_enabled_o,
  input  wire logic [NUM_MODULES-1:0] module_clk_en_o,
  input  wire logic [31:0]            boot_pc_o,
  input  wire logic [31:0]            fetch_paddr_o,
  input  wire logic                   fetch_uncached_o,
  input  wire logic                   boot_chip_select_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire logic seg = fetch_valid_i && !sys_reset_o && fetch_vaddr_i[31:29] == SEG_FIXED_UNCACHED;
  a_ext_quick_release: assert property ($past(reset_i) && oscillator_select_strap_i
    |-> ##1 sys_reset_o ##1 !sys_reset_o) else $error("external clock release late");
  a_xtal_settle_hold: assert property ($past(reset_i) && !oscillator_select_strap_i
    |-> sys_reset_o ##SETTLE_CYCLES sys_reset_o ##1 sys_reset_o ##1 !sys_reset_o)
    else $error("settle span");
  a_pll_off_boot: assert property (sys_reset_o |-> pll_enabled_o == '0 && !clk_from_pll_o)
    else $error("pll on in reset");
  a_clocks_all_run: assert property (sys_reset_o |-> &module_clk_en_o)
    else $error("module clock stopped");
  a_boot_pc_fixed: assert property (boot_pc_o == RESET_VECTOR) else $error("boot pc");
  a_segment_map: assert property (seg |=> fetch_uncached_o
    && fetch_paddr_o == ($past(fetch_vaddr_i) & 32'h1fff_ffff)) else $error("segment map");
  a_boot_cs_hit: assert property (seg && fetch_vaddr_i[28:0] < BOOT_CS_LIMIT
    |=> boot_chip_select_o) else $error("boot select missing");
  a_boot_cs_cause: assert property (boot_chip_select_o
    |-> $past(fetch_valid_i) && !$past(sys_reset_o)) else $error("stray boot select");
  a_sw_clock_ctrl: assert property (!sys_reset_o |=> pll_enabled_o == $past(pll_enable_i)
    && clk_from_pll_o == |$past(pll_enabled_o)) else $error("pll control");
  c_ext: cover property ($past(reset_i) && oscillator_select_strap_i);
  c_xtal: cover property ($past(reset_i) && !oscillator_select_strap_i);
  c_cs: cover property (boot_chip_select_o);
endmodule // bcrs_monitor
bind bcrs_sequencer bcrs_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) mon_u (
  .clock_i                   (clock_i),
  .reset_i                   (reset_i),
  .oscillator_select_strap_i (oscillator_select_strap_i),
  .pll_enable_i              (pll_enable_i),
  .fetch_valid_i             (fetch_valid_i),
  .fetch_vaddr_i             (fetch_vaddr_i),
  .sys_reset_o               (sys_reset_o),
  .clk_from_pll_o            (clk_from_pll_o),
  .pll_enabled_o             (pll_enabled_o),
  .module_clk_en_o           (module_clk_en_o),
  .boot_pc_o                 (boot_pc_o),
  .fetch_paddr_o             (fetch_paddr_o),
  .fetch_uncached_o          (fetch_uncached_o),
  .boot_chip_select_o        (boot_chip_select_o)
);

//--- dv/bcrs_boot_mem_model.sv
// Boot memory on the boot chip select; counts the accesses it serves.
// Assumes the select is a one-cycle pulse synchronous to clock_i.
`timescale 1ns/1ps
module bcrs_boot_mem_model (
  input  wire logic       clock_i,
  input  wire logic       boot_chip_select_i,
  output logic      [7:0] hits_o
);
  initial hits_o = 8'h00;
  always @(posedge clock_i) if (boot_chip_select_i) hits_o <= hits_o + 8'h01;
endmodule // bcrs_boot_mem_model

//--- dv/boot_clock_reset_sequencer_tb.sv
// Testbench for the boot clock and reset sequencer.
// Assumes a shortened settle count of 8 cycles.
`timescale 1ns/1ps
module boot_clock_reset_sequencer_tb;
  import bcrs_pkg::*;
  localparam int SETTLE = 8;
  logic clock_i = 0, reset_i = 1, oscillator_select_strap_i = 1, fetch_valid_i = 0;
  logic [NUM_PLLS-1:0] pll_enable_i = '0, pll_enabled_o;
  logic [NUM_MODULES-1:0] clk_gate_off_i = '0, module_clk_en_o;
  logic [NUM_MODULES*DIV_W-1:0] clk_div_i = '0;
  logic [31:0] fetch_vaddr_i = '0, boot_pc_o, fetch_paddr_o;
  logic sys_reset_o, clk_from_pll_o, fetch_uncached_o, boot_chip_select_o;
  logic [7:0] hits_o;
  int mismatches = 0, n_checks = 0;
  initial forever #2 clock_i = ~clock_i;
  bcrs_sequencer #(.SETTLE_CYCLES(SETTLE)) dut_u (
    .clock_i                   (clock_i),
    .reset_i                   (reset_i),
    .oscillator_select_strap_i (oscillator_select_strap_i),
    .pll_enable_i              (pll_enable_i),
    .clk_gate_off_i            (clk_gate_off_i),
    .clk_div_i                 (clk_div_i),
    .fetch_valid_i             (fetch_valid_i),
    .fetch_vaddr_i             (fetch_vaddr_i),
    .sys_reset_o               (sys_reset_o),
    .clk_from_pll_o            (clk_from_pll_o),
    .pll_enabled_o             (pll_enabled_o),
    .module_clk_en_o           (module_clk_en_o),
    .boot_pc_o                 (boot_pc_o),
    .fetch_paddr_o             (fetch_paddr_o),
    .fetch_uncached_o          (fetch_uncached_o),
    .boot_chip_select_o        (boot_chip_select_o)
  );
  bcrs_boot_mem_model mem_u (
    .clock_i            (clock_i),
    .boot_chip_select_i (boot_chip_select_o),
    .hits_o             (hits_o)
  );
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset with a strap value, software asking for PLLs all along.
  task automatic boot(logic ext, int exp_n);
    int n;
    n = 0;
    @(negedge clock_i);
    reset_i = 1;
    oscillator_select_strap_i = ext;
    pll_enable_i = 2'h3;
    repeat (5) @(negedge clock_i);
    chk("pll_rst", pll_enabled_o, 0);
    chk("clk_en_rst", module_clk_en_o, 8'hff);
    chk("boot_pc", boot_pc_o, RESET_VECTOR);
    reset_i = 0;
    while (sys_reset_o === 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
      if (sys_reset_o) chk("pll_hold", {clk_from_pll_o, pll_enabled_o}, 0);
    end
    chk("release", n, exp_n);
    pll_enable_i = 2'h0;
  endtask
  task automatic fetch(logic [31:0] va, logic exp_cs);
    fetch_valid_i = 1;
    fetch_vaddr_i = va;
    @(negedge clock_i);
    chk("paddr", fetch_paddr_o, va & 32'h1fff_ffff);
    chk("uncached", fetch_uncached_o, 1);
    chk("boot_cs", boot_chip_select_o, exp_cs);
  endtask
  task automatic sw_ctrl();
    int n;
    n = 0;
    pll_enable_i = 2'h2;
    clk_gate_off_i = 8'h01;
    clk_div_i = 32'h10;
    repeat (2) @(negedge clock_i);
    chk("pll_sw", {clk_from_pll_o, pll_enabled_o}, 3'h6);
    repeat (8) begin
      @(negedge clock_i);
      chk("gated", module_clk_en_o[0], 0);
      n += module_clk_en_o[1];
    end
    chk("divided", n, 4);
  endtask
  initial begin
    boot(1'b1, 2);
    fetch(RESET_VECTOR, 1);
    fetch(32'ha3ff_fffc, 1);
    fetch(32'ha400_0000, 0);
    fetch_valid_i = 0;
    @(negedge clock_i);
    chk("cs_idle", boot_chip_select_o, 0);
    chk("mem_hits", hits_o, 2);
    sw_ctrl();
    boot(1'b0, SETTLE + 2);
    fetch(RESET_VECTOR, 1);
    wrap_up();
  end
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule // boot_clock_reset_sequencer_tb
